// File: clk_ctrl.sv
// Chosen here: register access over APB and the placing of the registers.
`default_nettype none
module clk_ctrl (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic low_freq_clock,
    input wire logic primary_clock,
    input wire logic rc_ready_in,
    input wire logic xtal_present_in,
    input wire logic pll_locked_in,
    input wire logic cpu_sleep_req,
    input wire logic cpu_instr_done,
    input wire logic wake_irq,
    output logic xtal_enable_bit,
    output logic xtal_bypass_bit,
    output logic [1:0] rc_freq_select,
    output logic primary_source_select,
    output logic pll_enable,
    output logic [7:0] pll_ratio,
    output logic [clk_ctrl_pkg::GAIN_W-1:0] pll_gain_out,
    output logic pll_halve_bit,
    output logic [1:0] master_source_select,
    output logic [2:0] master_scaler_setting,
    output logic usb_clk_enable,
    output logic core_clk_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int GAIN_W_P = clk_ctrl_pkg::GAIN_W;
    localparam int CW = clk_ctrl_pkg::CNT_W;

    function automatic logic [GAIN_W_P-1:0] clamp_gain(input logic [GAIN_W_P-1:0] g,
                                                        input logic [GAIN_W_P-1:0] c);
        clamp_gain = (g > c) ? c : g;
    endfunction : clamp_gain

    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction : hit

    // synchronise pins and slow clock
    logic [4:0] sync_q;
    clk_sync2 #(.W(5)) u_sync (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .async_in({low_freq_clock, primary_clock, rc_ready_in, xtal_present_in, pll_locked_in}),
        .sync_out(sync_q)
    );
    logic slow_s, prim_s, rc_s, xtal_s, lock_s;
    assign {slow_s, prim_s, rc_s, xtal_s, lock_s} = sync_q;

    logic slow_d1_q, prim_d1_q;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            slow_d1_q <= 1'b0;
            prim_d1_q <= 1'b0;
        end else begin
            slow_d1_q <= slow_s;
            prim_d1_q <= prim_s;
        end
    end
    logic slow_rise, slow_fall, prim_rise;
    assign slow_rise = slow_s & ~slow_d1_q;
    assign slow_fall = ~slow_s & slow_d1_q;
    assign prim_rise = prim_s & ~prim_d1_q;

    // bus strobes
    logic wr_en, rd_en;
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;

    // oscillator control
    logic [7:0] xtal_startup_count;
    logic osc_wr, meas_wr, pll_wr, sys_wr;
    assign osc_wr = wr_en & hit(paddr, clk_ctrl_pkg::OSC_CTRL_ADDR);
    assign meas_wr = wr_en & hit(paddr, clk_ctrl_pkg::FREQ_METER_ADDR);
    assign pll_wr = wr_en & hit(paddr, clk_ctrl_pkg::PLL_CFG_ADDR);
    assign sys_wr = wr_en & hit(paddr, clk_ctrl_pkg::SYS_CFG_ADDR);

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            xtal_enable_bit <= 1'b0;
            xtal_bypass_bit <= 1'b0;
            rc_freq_select <= clk_ctrl_pkg::RC_FREQ_4MHZ;
            xtal_startup_count <= 8'h00;
            primary_source_select <= 1'b0;
        end else if (osc_wr) begin
            xtal_bypass_bit <= pwdata[clk_ctrl_pkg::XBY_BIT];
            xtal_enable_bit <= pwdata[clk_ctrl_pkg::XEN_BIT];
            rc_freq_select <= pwdata[clk_ctrl_pkg::RCF_LSB +: 2];
            xtal_startup_count <= pwdata[clk_ctrl_pkg::XST_LSB +: 8];
            primary_source_select <= pwdata[clk_ctrl_pkg::PSEL_BIT];
        end
    end

    // crystal startup counter on slow clock / 8
    logic [2:0] xpre_q;
    logic [7:0] xcnt_q;
    logic xtal_stable_flag, xtal_counting_q;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            xpre_q <= 3'h0;
            xcnt_q <= 8'h00;
            xtal_counting_q <= 1'b0;
            xtal_stable_flag <= 1'b0;
        end else if (osc_wr) begin
            xpre_q <= 3'h0;
            xcnt_q <= pwdata[clk_ctrl_pkg::XST_LSB +: 8];
            xtal_counting_q <= pwdata[clk_ctrl_pkg::XEN_BIT] | pwdata[clk_ctrl_pkg::XBY_BIT];
            if (!(xtal_enable_bit && pwdata[clk_ctrl_pkg::XEN_BIT])) begin
                xtal_stable_flag <= pwdata[clk_ctrl_pkg::XBY_BIT] & xtal_stable_flag;
            end
        end else if (xtal_counting_q && slow_rise) begin
            xpre_q <= xpre_q + 3'h1;
            if (xpre_q == clk_ctrl_pkg::XTAL_PREDIV) begin
                if (xcnt_q == 8'h00) begin
                    xtal_stable_flag <= 1'b1;
                    xtal_counting_q <= 1'b0;
                end else begin
                    xcnt_q <= xcnt_q - 8'h01;
                end
            end
        end
    end

    // rc stable tracking
    logic rc_stable_flag, rc_stable_d1_q, xtal_stable_d1_q, psel_d1_q;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rc_stable_flag <= 1'b0;
            rc_stable_d1_q <= 1'b0;
            xtal_stable_d1_q <= 1'b0;
            psel_d1_q <= 1'b0;
        end else begin
            rc_stable_flag <= rc_s & ~(osc_wr && pwdata[clk_ctrl_pkg::RCF_LSB +: 2] != rc_freq_select);
            rc_stable_d1_q <= rc_stable_flag;
            xtal_stable_d1_q <= xtal_stable_flag;
            psel_d1_q <= primary_source_select;
        end
    end

    // glitch-free primary switch: hold off for a settle window, then report
    logic primary_switch_done_flag;
    logic [7:0] sw_cnt_q;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sw_cnt_q <= 8'h00;
            primary_switch_done_flag <= 1'b1;
        end else if (primary_source_select != psel_d1_q) begin
            sw_cnt_q <= clk_ctrl_pkg::SWITCH_CYCLES;
            primary_switch_done_flag <= 1'b0;
        end else if (sw_cnt_q != 8'h00) begin
            sw_cnt_q <= sw_cnt_q - 8'h01;
        end else begin
            // crystal presence decides the outcome when the crystal is chosen
            primary_switch_done_flag <= ~primary_source_select | xtal_s;
        end
    end

    // frequency meter
    clk_ctrl_pkg::meas_state_t meas_q;
    logic [CW-1:0] measured_cycle_count;
    logic [4:0] per_q;
    logic measure_done_flag, meas_start;
    assign meas_start = (meas_wr & pwdata[clk_ctrl_pkg::MEAS_RESTART_BIT])
        | (~primary_source_select & rc_stable_flag & ~rc_stable_d1_q)
        | (primary_source_select & xtal_stable_flag & ~xtal_stable_d1_q)
        | (primary_source_select != psel_d1_q);
    assign measure_done_flag = (meas_q == clk_ctrl_pkg::MEAS_DONE);
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            meas_q <= clk_ctrl_pkg::MEAS_IDLE;
            measured_cycle_count <= '0;
            per_q <= 5'h00;
        end else if (meas_start) begin
            meas_q <= clk_ctrl_pkg::MEAS_RUN;
            measured_cycle_count <= '0;
            per_q <= 5'h00;
        end else begin
            case (meas_q)
                clk_ctrl_pkg::MEAS_RUN: begin
                    // counting opens at the first falling edge, so the window is whole slow periods
                    if (prim_rise && per_q != 5'h00) begin
                        measured_cycle_count <= measured_cycle_count + 1'b1;
                    end
                    if (slow_fall) begin
                        per_q <= per_q + 5'h01;
                        if (per_q == clk_ctrl_pkg::MEAS_PERIODS) begin
                            meas_q <= clk_ctrl_pkg::MEAS_DONE;
                        end
                    end
                end
                clk_ctrl_pkg::MEAS_IDLE, clk_ctrl_pkg::MEAS_DONE: begin
                    meas_q <= meas_q;
                end
                default: begin
                    meas_q <= clk_ctrl_pkg::MEAS_IDLE;
                end
            endcase
        end
    end

    // pll configuration
    logic [GAIN_W_P-1:0] pll_gain_field, pll_gain_ceiling;
    logic [7:0] pll_settle_count;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pll_ratio <= 8'h00;
            pll_gain_field <= '0;
            pll_settle_count <= 8'h00;
        end else if (pll_wr) begin
            pll_ratio <= pwdata[clk_ctrl_pkg::DIV_LSB +: 8];
            pll_gain_field <= pwdata[clk_ctrl_pkg::GAIN_LSB +: GAIN_W_P];
            pll_settle_count <= pwdata[clk_ctrl_pkg::CNT_LSB +: 8];
        end
    end
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pll_gain_ceiling <= clk_ctrl_pkg::GAIN_CEIL_RST;
        end else if (wr_en && hit(paddr, clk_ctrl_pkg::CEIL_ADDR)) begin
            pll_gain_ceiling <= pwdata[GAIN_W_P-1:0];
        end
    end
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pll_gain_out <= '0;
        end else begin
            pll_gain_out <= clamp_gain(pll_gain_field, pll_gain_ceiling);
        end
    end

    // pll power down after two slow cycles, settle counter
    logic pll_cfg_on;
    logic [1:0] off_cnt_q;
    logic [7:0] settle_q;
    logic pll_settled_q;
    assign pll_cfg_on = (pll_ratio != 8'h00) && (pll_gain_field != '0);
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pll_enable <= 1'b0;
            off_cnt_q <= 2'h0;
        end else if (pll_cfg_on) begin
            pll_enable <= 1'b1;
            off_cnt_q <= 2'h0;
        end else if (pll_enable && slow_rise) begin
            off_cnt_q <= off_cnt_q + 2'h1;
            if (off_cnt_q + 2'h1 == clk_ctrl_pkg::PLL_OFF_DELAY) begin
                pll_enable <= 1'b0;
            end
        end
    end
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            settle_q <= 8'h00;
            pll_settled_q <= 1'b0;
        end else if (pll_wr) begin
            settle_q <= pwdata[clk_ctrl_pkg::CNT_LSB +: 8];
            pll_settled_q <= 1'b0;
        end else if (!pll_cfg_on) begin
            pll_settled_q <= 1'b0;
        end else if (!pll_settled_q && slow_rise) begin
            if (settle_q == 8'h00) begin
                pll_settled_q <= lock_s | 1'b1;
            end else begin
                settle_q <= settle_q - 8'h01;
            end
        end
    end

    // system clock selector and prescaler configuration
    logic system_clock_ready_flag;
    logic [2:0] rdy_cnt_q;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            master_source_select <= clk_ctrl_pkg::CSS_PRIMARY;
            master_scaler_setting <= 3'h0;
            pll_halve_bit <= 1'b0;
        end else if (sys_wr) begin
            master_source_select <= pwdata[clk_ctrl_pkg::CSS_LSB +: 2];
            master_scaler_setting <= pwdata[clk_ctrl_pkg::MASTER_SCALER_SETTING_LSB +: 3];
            pll_halve_bit <= pwdata[clk_ctrl_pkg::HALVE_BIT];
        end
    end
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rdy_cnt_q <= 3'h0;
            system_clock_ready_flag <= 1'b1;
        end else if (sys_wr) begin
            rdy_cnt_q <= 3'h0;
            system_clock_ready_flag <= 1'b0;
        end else if (!system_clock_ready_flag && slow_rise) begin
            rdy_cnt_q <= rdy_cnt_q + 3'h1;
            if (rdy_cnt_q + 3'h1 == clk_ctrl_pkg::SETTLE_CYCLES) begin
                system_clock_ready_flag <= 1'b1;
            end
        end
    end

    // usb clock enable follows a settled pll
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            usb_clk_enable <= 1'b0;
        end else begin
            usb_clk_enable <= pll_settled_q & pll_enable;
        end
    end

    // processor sleep gating, changed only on the clock edge so no runt pulse
    logic deep_sleep_select;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            deep_sleep_select <= 1'b0;
        end else if (wr_en && hit(paddr, clk_ctrl_pkg::WAKE_ADDR)) begin
            deep_sleep_select <= pwdata[0];
        end
    end
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            core_clk_enable <= 1'b1;
        end else if (wake_irq) begin
            core_clk_enable <= 1'b1;
        end else if (cpu_sleep_req && cpu_instr_done && !deep_sleep_select) begin
            core_clk_enable <= 1'b0;
        end
    end

    // apb read path and answer
    logic [31:0] rdata_d;
    always_comb begin
        rdata_d = clk_ctrl_pkg::READ_ZERO;
        case (paddr)
            clk_ctrl_pkg::OSC_CTRL_ADDR: begin
                rdata_d[clk_ctrl_pkg::XBY_BIT] = xtal_bypass_bit;
                rdata_d[clk_ctrl_pkg::XEN_BIT] = xtal_enable_bit;
                rdata_d[clk_ctrl_pkg::RCF_LSB +: 2] = rc_freq_select;
                rdata_d[clk_ctrl_pkg::XST_LSB +: 8] = xtal_startup_count;
                rdata_d[clk_ctrl_pkg::PSEL_BIT] = primary_source_select;
            end
            clk_ctrl_pkg::FREQ_METER_ADDR: begin
                rdata_d[CW-1:0] = measured_cycle_count;
                rdata_d[clk_ctrl_pkg::MEAS_RDY_BIT] = measure_done_flag;
            end
            clk_ctrl_pkg::PLL_CFG_ADDR: begin
                rdata_d[clk_ctrl_pkg::DIV_LSB +: 8] = pll_ratio;
                rdata_d[clk_ctrl_pkg::CNT_LSB +: 8] = pll_settle_count;
                rdata_d[clk_ctrl_pkg::GAIN_LSB +: GAIN_W_P] = pll_gain_field;
            end
            clk_ctrl_pkg::SYS_CFG_ADDR: begin
                rdata_d[clk_ctrl_pkg::CSS_LSB +: 2] = master_source_select;
                rdata_d[clk_ctrl_pkg::MASTER_SCALER_SETTING_LSB +: 3] = master_scaler_setting;
                rdata_d[clk_ctrl_pkg::HALVE_BIT] = pll_halve_bit;
            end
            clk_ctrl_pkg::STATUS_ADDR: begin
                rdata_d[clk_ctrl_pkg::ST_XTAL] = xtal_stable_flag;
                rdata_d[clk_ctrl_pkg::ST_PLL] = pll_settled_q;
                rdata_d[clk_ctrl_pkg::ST_SYSRDY] = system_clock_ready_flag;
                rdata_d[clk_ctrl_pkg::ST_PSW] = primary_switch_done_flag;
                rdata_d[clk_ctrl_pkg::ST_RC] = rc_stable_flag;
            end
            clk_ctrl_pkg::CEIL_ADDR: begin
                rdata_d[GAIN_W_P-1:0] = pll_gain_ceiling;
            end
            clk_ctrl_pkg::WAKE_ADDR: begin
                rdata_d[0] = deep_sleep_select;
            end
            default: begin
                rdata_d = clk_ctrl_pkg::READ_ZERO;
            end
        endcase
    end
    logic mapped;
    assign mapped = (paddr[1:0] == 2'h0) && (paddr <= clk_ctrl_pkg::WAKE_ADDR);
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            prdata <= clk_ctrl_pkg::READ_ZERO;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            if (psel && !penable && !pwrite) begin
                prdata <= rdata_d;
            end
        end
    end
endmodule : clk_ctrl
`default_nettype wire

// File: clk_ctrl_monitor.sv
`default_nettype none
module clk_ctrl_monitor (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic pll_enable,
    input wire logic [7:0] pll_ratio,
    input wire logic pll_halve_bit,
    input wire logic [1:0] master_source_select,
    input wire logic [2:0] master_scaler_setting,
    input wire logic [1:0] rc_freq_select,
    input wire logic cpu_instr_done,
    input wire logic wake_irq,
    input wire logic core_clk_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    logic wr_cfg;
    logic [31:0] wd_q;
    assign wr_cfg = psel && penable && pwrite && paddr == clk_ctrl_pkg::SYS_CFG_ADDR;
    always_ff @(posedge clk_sys) begin
        wd_q <= pwdata;
    end
    a_pready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready is not one pulse after setup");
    a_bad_addr: assert property (psel && !penable && paddr > 8'h18 |=> pready && pslverr)
        else $error("unmapped access not refused");
    a_sys_cfg: assert property (wr_cfg |=> master_source_select == wd_q[1:0] &&
        master_scaler_setting == wd_q[6:4] && pll_halve_bit == wd_q[12])
        else $error("system clock config not applied");
    a_pll_off: assert property (pll_enable && pll_ratio == 8'h00 |-> ##[0:400] !pll_enable)
        else $error("pll not powered down");
    a_pll_on: assert property ($rose(pll_enable) |-> pll_ratio != 8'h00)
        else $error("pll enabled with zero ratio");
    a_gate_done: assert property ($fell(core_clk_enable) |-> $past(cpu_instr_done))
        else $error("core clock stopped mid instruction");
    a_wake_restart: assert property (!core_clk_enable && wake_irq |-> ##[1:8] core_clk_enable)
        else $error("core clock not restarted by interrupt");
    a_reset_state: assert property ($rose(resetn) |-> master_source_select == 2'h1 &&
        rc_freq_select == 2'h0 && core_clk_enable)
        else $error("wrong state after reset");
    c_cfg: cover property (wr_cfg);
    c_sleep: cover property ($fell(core_clk_enable));
    c_pll_off: cover property ($fell(pll_enable));
endmodule : clk_ctrl_monitor
bind clk_ctrl clk_ctrl_monitor u_mon (.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .pll_enable(pll_enable), .pll_ratio(pll_ratio), .pll_halve_bit(pll_halve_bit),
    .master_source_select(master_source_select), .master_scaler_setting(master_scaler_setting),
    .rc_freq_select(rc_freq_select), .cpu_instr_done(cpu_instr_done), .wake_irq(wake_irq),
    .core_clk_enable(core_clk_enable));
`default_nettype wire

// File: clk_ctrl_pkg.sv
`default_nettype none
package clk_ctrl_pkg;
    // register byte addresses
    localparam logic [7:0] OSC_CTRL_ADDR = 8'h00;
    localparam logic [7:0] FREQ_METER_ADDR = 8'h04;
    localparam logic [7:0] PLL_CFG_ADDR = 8'h08;
    localparam logic [7:0] SYS_CFG_ADDR = 8'h0c;
    localparam logic [7:0] STATUS_ADDR = 8'h10;
    localparam logic [7:0] CEIL_ADDR = 8'h14;
    localparam logic [7:0] WAKE_ADDR = 8'h18;
    // oscillator control fields
    localparam int XBY_BIT = 0;
    localparam int XEN_BIT = 1;
    localparam int RCF_LSB = 4;
    localparam int XST_LSB = 8;
    localparam int PSEL_BIT = 24;
    // frequency meter fields
    localparam int MEAS_RDY_BIT = 16;
    localparam int MEAS_RESTART_BIT = 20;
    // pll config fields
    localparam int DIV_LSB = 0;
    localparam int CNT_LSB = 8;
    localparam int GAIN_LSB = 16;
    // system clock config fields
    localparam int CSS_LSB = 0;
    localparam int MASTER_SCALER_SETTING_LSB = 4;
    localparam int HALVE_BIT = 12;
    // status bits
    localparam int ST_XTAL = 0;
    localparam int ST_PLL = 1;
    localparam int ST_SYSRDY = 3;
    localparam int ST_PSW = 16;
    localparam int ST_RC = 17;
    // widths and counts
    localparam int CNT_W = 16;
    localparam int GAIN_W = 11;
    localparam logic [4:0] MEAS_PERIODS = 5'h10;
    localparam logic [2:0] XTAL_PREDIV = 3'h7;
    localparam logic [1:0] PLL_OFF_DELAY = 2'h2;
    localparam logic [1:0] RC_FREQ_4MHZ = 2'h0;
    localparam logic [2:0] MASTER_SCALER_SETTING_DIV3 = 3'h7;
    localparam logic [1:0] CSS_SLOW = 2'h0;
    localparam logic [1:0] CSS_PRIMARY = 2'h1;
    localparam logic [1:0] CSS_PLL = 2'h2;
    localparam logic [2:0] SETTLE_CYCLES = 3'h4;
    localparam logic [7:0] SWITCH_CYCLES = 8'h40;
    localparam logic [GAIN_W-1:0] GAIN_CEIL_RST = 11'h7ff;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;
    localparam real USB_CLK_MHZ = 48.0;
    typedef enum logic [1:0] {
        MEAS_IDLE,
        MEAS_RUN,
        MEAS_DONE
    } meas_state_t;
endpackage : clk_ctrl_pkg
`default_nettype wire

// File: clk_osc_model.sv
`default_nettype none
module clk_osc_model (
    input wire logic pll_enable,
    output logic low_freq_clock,
    output logic primary_clock,
    output logic rc_ready_in,
    output logic xtal_present_in,
    output wire logic pll_locked_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // slow period 320 ns, primary 40 ns: 128 primary cycles per 16 slow periods
    initial begin
        low_freq_clock = 1'b0;
        primary_clock = 1'b0;
        rc_ready_in = 1'b1;
        xtal_present_in = 1'b1;
        fork
            forever #160 low_freq_clock = ~low_freq_clock;
            forever #20 primary_clock = ~primary_clock;
        join
    end
    assign #200 pll_locked_in = pll_enable;
endmodule : clk_osc_model
`default_nettype wire

// File: clk_sync2.sv
`default_nettype none
module clk_sync2 #(
    parameter int W = 1
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [W-1:0] meta_q;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : clk_sync2
`default_nettype wire

// File: main_clock_pll_master_clock_ctrl_bench.sv
`default_nettype none
module main_clock_pll_master_clock_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, resetn, psel, penable, pwrite, cpu_sleep_req, cpu_instr_done, wake_irq, err;
    logic low_freq_clock, primary_clock, rc_ready_in, xtal_present_in, pll_locked_in, pready, pslverr;
    logic xtal_enable_bit, xtal_bypass_bit, primary_source_select, pll_enable, pll_halve_bit, core_clk_enable;
    logic usb_clk_enable;
    logic [7:0] paddr, pll_ratio;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] rc_freq_select, master_source_select;
    logic [2:0] master_scaler_setting;
    logic [10:0] pll_gain_out;
    int n_fail, checks_done, cyc, n, i;
    clk_ctrl uut (.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .low_freq_clock(low_freq_clock), .primary_clock(primary_clock), .rc_ready_in(rc_ready_in),
        .xtal_present_in(xtal_present_in), .pll_locked_in(pll_locked_in), .cpu_sleep_req(cpu_sleep_req),
        .cpu_instr_done(cpu_instr_done), .wake_irq(wake_irq), .xtal_enable_bit(xtal_enable_bit),
        .xtal_bypass_bit(xtal_bypass_bit), .rc_freq_select(rc_freq_select),
        .primary_source_select(primary_source_select), .pll_enable(pll_enable), .pll_ratio(pll_ratio),
        .pll_gain_out(pll_gain_out), .pll_halve_bit(pll_halve_bit),
        .master_source_select(master_source_select), .master_scaler_setting(master_scaler_setting),
        .usb_clk_enable(usb_clk_enable), .core_clk_enable(core_clk_enable));
    clk_osc_model u_osc (.pll_enable(pll_enable), .low_freq_clock(low_freq_clock),
        .primary_clock(primary_clock), .rc_ready_in(rc_ready_in), .xtal_present_in(xtal_present_in),
        .pll_locked_in(pll_locked_in));
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : print_verdict
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_fail++;
            print_verdict();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1 && ++k < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb
    task automatic poll(input logic [7:0] a, input int b);
        int k;
        k = 0;
        do apb(1'b0, a, 32'h0); while (rd[b] !== 1'b1 && ++k < 3000);
        chk("poll", 32'(rd[b]), 32'h1);
    endtask : poll
    initial begin
        {resetn, psel, penable, pwrite, cpu_sleep_req, cpu_instr_done, wake_irq} = 7'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        {n_fail, checks_done, cyc} = {32'h0, 32'h0, 32'h0};
        repeat (4) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        chk("css", 32'(master_source_select), 32'h1);
        chk("rcf", 32'(rc_freq_select), 32'h0);
        chk("core", 32'(core_clk_enable), 32'h1);
        apb(1'b0, 8'h1c, 32'h0);
        chk("slverr", 32'(err), 32'h1);
        $display("reset and bus test done");
        apb(1'b1, clk_ctrl_pkg::SYS_CFG_ADDR, 32'h0);
        poll(clk_ctrl_pkg::STATUS_ADDR, clk_ctrl_pkg::ST_SYSRDY);
        apb(1'b1, clk_ctrl_pkg::OSC_CTRL_ADDR, 32'h0000_0202);
        poll(clk_ctrl_pkg::STATUS_ADDR, clk_ctrl_pkg::ST_XTAL);
        apb(1'b1, clk_ctrl_pkg::OSC_CTRL_ADDR, 32'h0100_0202);
        poll(clk_ctrl_pkg::OSC_CTRL_ADDR, clk_ctrl_pkg::PSEL_BIT);
        chk("psel", 32'(primary_source_select), 32'h1);
        poll(clk_ctrl_pkg::STATUS_ADDR, clk_ctrl_pkg::ST_PSW);
        apb(1'b1, clk_ctrl_pkg::FREQ_METER_ADDR, 32'h0010_0000);
        poll(clk_ctrl_pkg::FREQ_METER_ADDR, clk_ctrl_pkg::MEAS_RDY_BIT);
        chk("count", 32'(rd[15:0] >= 16'd127 && rd[15:0] <= 16'd129), 32'h1);
        apb(1'b1, clk_ctrl_pkg::OSC_CTRL_ADDR, 32'h0100_0203);
        apb(1'b1, clk_ctrl_pkg::OSC_CTRL_ADDR, 32'h0100_0201);
        chk("bypass", 32'({xtal_bypass_bit, xtal_enable_bit}), 32'h2);
        $display("crystal test done");
        apb(1'b1, clk_ctrl_pkg::CEIL_ADDR, 32'h8);
        apb(1'b1, clk_ctrl_pkg::PLL_CFG_ADDR, 32'h0010_0203);
        poll(clk_ctrl_pkg::STATUS_ADDR, clk_ctrl_pkg::ST_PLL);
        chk("gain", 32'(pll_gain_out), 32'h8);
        chk("ratio", 32'(pll_ratio), 32'h3);
        chk("usb", 32'(usb_clk_enable), 32'h1);
        apb(1'b1, clk_ctrl_pkg::PLL_CFG_ADDR, 32'h0001_0200);
        for (n = 0; n < 400 && pll_enable !== 1'b0; n++) @(posedge clk_sys);
        chk("pll_off", 32'(pll_enable), 32'h0);
        chk("usb_off", 32'(usb_clk_enable), 32'h0);
        $display("pll test done");
        apb(1'b1, clk_ctrl_pkg::SYS_CFG_ADDR, 32'h0000_1002);
        chk("halve", 32'({pll_halve_bit, master_source_select}), 32'h6);
        apb(1'b0, clk_ctrl_pkg::STATUS_ADDR, 32'h0);
        chk("ready", 32'(rd[clk_ctrl_pkg::ST_SYSRDY]), 32'h0);
        for (i = 0; i < 8; i++) begin
            apb(1'b1, clk_ctrl_pkg::SYS_CFG_ADDR, (32'(i) << 4) | 32'h1);
            chk("master_scaler_setting", 32'(master_scaler_setting), 32'(i));
        end
        apb(1'b1, clk_ctrl_pkg::OSC_CTRL_ADDR, 32'h0100_0211);
        poll(clk_ctrl_pkg::STATUS_ADDR, clk_ctrl_pkg::ST_RC);
        chk("rcf8", 32'(rc_freq_select), 32'h1);
        apb(1'b1, clk_ctrl_pkg::PLL_CFG_ADDR, 32'h0010_0203);
        poll(clk_ctrl_pkg::STATUS_ADDR, clk_ctrl_pkg::ST_PLL);
        apb(1'b1, clk_ctrl_pkg::SYS_CFG_ADDR, 32'h0000_0002);
        chk("css_pll", 32'(master_source_select), 32'h2);
        $display("system clock test done");
        apb(1'b1, clk_ctrl_pkg::WAKE_ADDR, 32'h0);
        cpu_sleep_req <= 1'b1;
        repeat (6) @(posedge clk_sys);
        chk("busy", 32'(core_clk_enable), 32'h1);
        cpu_instr_done <= 1'b1;
        for (n = 0; n < 20 && core_clk_enable !== 1'b0; n++) @(posedge clk_sys);
        chk("sleep", 32'(core_clk_enable), 32'h0);
        {cpu_sleep_req, cpu_instr_done, wake_irq} <= 3'b001;
        for (n = 0; n < 20 && core_clk_enable !== 1'b1; n++) @(posedge clk_sys);
        chk("wake", 32'(core_clk_enable), 32'h1);
        $display("sleep test done");
        print_verdict();
    end
endmodule : main_clock_pll_master_clock_ctrl_bench
`default_nettype wire
